// >>> logic/ioc_pkg.sv
/*
  Shared constants of the inertial output calibration block: register
  byte addresses, field widths, reset values, frame layout and command bits.
  Assumes nothing of its surroundings; imported by scoped name only.
*/
`default_nettype none
package ioc_pkg;
  // ----------------------------------------------------------------
  // register byte addresses (6-bit space, even = lower byte)
  // ----------------------------------------------------------------
  localparam logic [5:0] A_XA_OUT  = 6'h04;
  localparam logic [5:0] A_YA_OUT  = 6'h06;
  localparam logic [5:0] A_XT_OUT  = 6'h0C;
  localparam logic [5:0] A_YT_OUT  = 6'h0E;
  localparam logic [5:0] A_XA_OFS  = 6'h10;
  localparam logic [5:0] A_YA_OFS  = 6'h12;
  localparam logic [5:0] A_XA_GAIN = 6'h14;
  localparam logic [5:0] A_YA_GAIN = 6'h16;
  localparam logic [5:0] A_XT_OFS  = 6'h18;
  localparam logic [5:0] A_YT_OFS  = 6'h1A;
  localparam logic [5:0] A_XT_GAIN = 6'h1C;
  localparam logic [5:0] A_YT_GAIN = 6'h1E;
  localparam logic [5:0] A_AVG     = 6'h38;
  localparam logic [5:0] A_CMD     = 6'h3E;
  // ----------------------------------------------------------------
  // field widths and values
  // ----------------------------------------------------------------
  localparam int RAW_W      = 14;
  localparam int ACC_OFS_W  = 12;
  localparam int TILT_OFS_W = 9;
  localparam int GAIN_W     = 12;
  localparam int GAIN_FRAC  = 11;
  localparam logic [11:0] OFS_RST  = 12'h000;
  localparam logic [11:0] GAIN_RST = 12'h800;
  localparam logic [15:0] AVG_RST  = 16'h0000;
  localparam logic signed [16:0] ACC_OFS_MAX  = 17'sh007FF;
  localparam logic signed [16:0] TILT_OFS_MAX = 17'sh000FF;
  // ----------------------------------------------------------------
  // serial frame layout and command bits
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int WR_BIT    = 15;
  localparam int ADDR_HI   = 13;
  localparam int ADDR_LO   = 8;
  localparam int CMD_NULL  = 0;
  localparam int CMD_FLASH = 3;
  // ----------------------------------------------------------------
  // nonvolatile store: eight calibration words plus a validity mark
  // ----------------------------------------------------------------
  localparam int NV_WORDS = 9;
  localparam int NV_SIG_IDX = 8;
  localparam logic [4:0] NV_BASE_W = 5'h08;
  localparam logic [15:0] NV_SIG = 16'hA5C3;  // arbitrary marker value
  typedef enum logic {IOC_RESTORE, IOC_RUN} ioc_phase_t;
endpackage
`default_nettype wire

// >>> logic/ioc_cal_axis.sv
/*
  One calibration lane: result = gain * (raw + offset), gain unity at
  2^GAIN_FRAC, saturated to the raw range and sign-extended.
  Purely combinational; the instantiating module registers the result.
*/
`timescale 1ns/10ps
`default_nettype none
module ioc_cal_axis #(
  parameter int RAW_W  = 14,
  parameter int OFS_W  = 12,
  parameter int GAIN_W = 12,
  parameter int FRAC   = 11,
  parameter int OUT_W  = 16
) (
  input  wire logic [RAW_W-1:0]  raw,     // uncalibrated sample, signed
  input  wire logic [OFS_W-1:0]  offset,  // signed offset
  input  wire logic [GAIN_W-1:0] gain,    // unsigned gain
  output logic      [OUT_W-1:0]  result   // calibrated sample
);
  localparam int P_W = RAW_W + GAIN_W + 2;
  localparam logic signed [P_W-1:0] HI = P_W'((64'sd1 <<< (RAW_W-1)) - 64'sd1);
  localparam logic signed [P_W-1:0] LO = -HI - P_W'(1);

  logic signed [RAW_W:0] sum;
  logic signed [P_W-1:0] prod;
  logic signed [P_W-1:0] scaled;
  logic signed [P_W-1:0] sat;

  always_comb begin
    sum    = (RAW_W+1)'($signed(raw)) + (RAW_W+1)'($signed(offset));
    prod   = sum * $signed({1'b0, gain});
    scaled = prod >>> FRAC;
    // saturation keeps a large gain from wrapping the sign
    if (scaled > HI) begin
      sat = HI;
    end else if (scaled < LO) begin
      sat = LO;
    end else begin
      sat = scaled;
    end
    result = OUT_W'($signed(sat[RAW_W-1:0]));
  end
endmodule
`default_nettype wire

// >>> logic/ioc_top.sv
/*
  Calibration stage of a dual-axis accelerometer / inclinometer with its
  serial register port (16-bit frames, one byte written per frame).
  Assumes raw samples arrive on MCLK with a one-cycle RAW_VALID strobe and
  that the serial pins are asynchronous to MCLK and slow against it.
  // Operation
  // - every 16-bit register has an upper byte (15:8) and lower byte (7:0), each addressed alone.
  // - accel offsets and all gains hold 12 bits, tilt offsets 9 bits, right-aligned.
  // - offsets are twos complement, gains straight binary.
  // - each calibrated output is gain times (raw sample plus offset).
  // - each of the four axes has its own offset and gain, used only for its own output.
  // - a null command loads every offset with the negated current output.
  // - accel offsets use bits 11:0, reset to zero, span +2047 to -2048.
  // - accel gains use bits 11:0, reset to 0x0800 as unity, span 0 to 4095.
  // - tilt offsets use bits 8:0, reset to zero, span +255 to -256.
  // - tilt gains use bits 11:0, reset to 0x0800, span 0 to 4095.
  // - calibration words are kept in a nonvolatile store and restored at start.
  // - the host may write any calibration register and the outputs follow it.
  // - a frame with bit 15 set writes data 7:0 to address 13:8; bit 15 clear reads.
  // - a read answers in the next frame with the odd byte first, then the even byte.
*/
`timescale 1ns/10ps
`default_nettype none
module ioc_top #(
  parameter int RAW_W = 14
) (
  input  wire logic             MCLK,               // 40 MHz clock
  input  wire logic             RST,                // async reset, high
  input  wire logic             SCLK,               // serial clock, idle high
  input  wire logic             CS_N,               // frame select, low
  input  wire logic             DIN,                // serial data in
  output logic                  DOUT,               // serial data out
  input  wire logic             RAW_VALID,          // raw samples strobe
  input  wire logic [RAW_W-1:0] RAW_X_ACCEL,        // raw x accel
  input  wire logic [RAW_W-1:0] RAW_Y_ACCEL,        // raw y accel
  input  wire logic [RAW_W-1:0] RAW_X_TILT,         // raw x tilt
  input  wire logic [RAW_W-1:0] RAW_Y_TILT,         // raw y tilt
  output logic      [15:0]      X_ACCEL_OUT,        // calibrated x accel
  output logic      [15:0]      Y_ACCEL_OUT,        // calibrated y accel
  output logic      [15:0]      X_TILT_OUT,         // calibrated x tilt
  output logic      [15:0]      Y_TILT_OUT,         // calibrated y tilt
  output logic                  OUT_VALID,          // outputs updated
  output logic      [15:0]      MOVING_AVERAGE_COUNT // to sample filter
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ioc_pkg::ioc_phase_t phase;
    logic [2:0]          sclk_p;
    logic [2:0]          csn_p;
    logic [1:0]          din_p;
    logic [4:0]          bit_cnt;
    logic [15:0]         rx;
    logic [15:0]         tx;
    logic                dout;
    logic [1:0][11:0]    aofs;
    logic [1:0][8:0]     tofs;
    logic [3:0][11:0]    gain;
    logic [15:0]         avg;
    logic [3:0][15:0]    out;
    logic                out_valid;
    logic                flash_req;
  } ioc_state_t;

  localparam ioc_state_t RST_S = '{
    phase:   ioc_pkg::IOC_RESTORE,
    sclk_p:  3'h7,
    csn_p:   3'h7,
    aofs:    {2{ioc_pkg::OFS_RST}},
    tofs:    {2{ioc_pkg::OFS_RST[8:0]}},
    gain:    {4{ioc_pkg::GAIN_RST}},
    avg:     ioc_pkg::AVG_RST,
    default: '0
  };

  ioc_state_t       r;
  ioc_state_t       n;
  logic [3:0][15:0] cal_res;
  logic [15:0]      nv_mem [0:ioc_pkg::NV_WORDS-1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word read by address; unused calibration bits read as zero
  function automatic logic [15:0] rd_word(input ioc_state_t s, input logic [4:0] w);
    logic [15:0] d;
    d = 16'h0000;
    unique case ({w, 1'b0})
      ioc_pkg::A_XA_OUT:  d = s.out[0];
      ioc_pkg::A_YA_OUT:  d = s.out[1];
      ioc_pkg::A_XT_OUT:  d = s.out[2];
      ioc_pkg::A_YT_OUT:  d = s.out[3];
      ioc_pkg::A_XA_OFS:  d = {4'h0, s.aofs[0]};
      ioc_pkg::A_YA_OFS:  d = {4'h0, s.aofs[1]};
      ioc_pkg::A_XA_GAIN: d = {4'h0, s.gain[0]};
      ioc_pkg::A_YA_GAIN: d = {4'h0, s.gain[1]};
      ioc_pkg::A_XT_OFS:  d = {7'h00, s.tofs[0]};
      ioc_pkg::A_YT_OFS:  d = {7'h00, s.tofs[1]};
      ioc_pkg::A_XT_GAIN: d = {4'h0, s.gain[2]};
      ioc_pkg::A_YT_GAIN: d = {4'h0, s.gain[3]};
      ioc_pkg::A_AVG:     d = s.avg;
      default:            d = 16'h0000;
    endcase
    return d;
  endfunction

  // store one word; read-only and unmapped words are left alone
  function automatic ioc_state_t put_word(input ioc_state_t s, input logic [4:0] w,
                                          input logic [15:0] d);
    ioc_state_t t;
    t = s;
    unique case ({w, 1'b0})
      ioc_pkg::A_XA_OFS:  t.aofs[0] = d[11:0];
      ioc_pkg::A_YA_OFS:  t.aofs[1] = d[11:0];
      ioc_pkg::A_XA_GAIN: t.gain[0] = d[11:0];
      ioc_pkg::A_YA_GAIN: t.gain[1] = d[11:0];
      ioc_pkg::A_XT_OFS:  t.tofs[0] = d[8:0];
      ioc_pkg::A_YT_OFS:  t.tofs[1] = d[8:0];
      ioc_pkg::A_XT_GAIN: t.gain[2] = d[11:0];
      ioc_pkg::A_YT_GAIN: t.gain[3] = d[11:0];
      ioc_pkg::A_AVG:     t.avg     = d;
      default:            t = s;
    endcase
    return t;
  endfunction

  // negate an output and clamp it into the offset range
  function automatic logic [11:0] neg_sat(input logic [15:0] v,
                                          input logic signed [16:0] hi);
    logic signed [16:0] x;
    x = -(17'($signed(v)));
    if (x > hi) begin
      x = hi;
    end else if (x < -hi - 17'sd1) begin
      x = -hi - 17'sd1;
    end
    return x[11:0];
  endfunction

  // ----------------------------------------------------------------
  // per-axis datapath
  // ----------------------------------------------------------------
  ioc_cal_axis #(.RAW_W(RAW_W), .OFS_W(ioc_pkg::ACC_OFS_W)) u_xa (
    .raw    (RAW_X_ACCEL),
    .offset (r.aofs[0]),
    .gain   (r.gain[0]),
    .result (cal_res[0])
  );
  ioc_cal_axis #(.RAW_W(RAW_W), .OFS_W(ioc_pkg::ACC_OFS_W)) u_ya (
    .raw    (RAW_Y_ACCEL),
    .offset (r.aofs[1]),
    .gain   (r.gain[1]),
    .result (cal_res[1])
  );
  ioc_cal_axis #(.RAW_W(RAW_W), .OFS_W(ioc_pkg::TILT_OFS_W)) u_xt (
    .raw    (RAW_X_TILT),
    .offset (r.tofs[0]),
    .gain   (r.gain[2]),
    .result (cal_res[2])
  );
  ioc_cal_axis #(.RAW_W(RAW_W), .OFS_W(ioc_pkg::TILT_OFS_W)) u_yt (
    .raw    (RAW_Y_TILT),
    .offset (r.tofs[1]),
    .gain   (r.gain[3]),
    .result (cal_res[3])
  );

  // ----------------------------------------------------------------
  // null command offsets
  // ----------------------------------------------------------------
  // taken from the registered outputs, so a null cancels what the host
  // last read rather than a sample that is still on its way in
  logic [11:0] null_xa;
  logic [11:0] null_ya;
  logic [11:0] null_xt;
  logic [11:0] null_yt;

  assign null_xa = neg_sat(r.out[0], ioc_pkg::ACC_OFS_MAX);
  assign null_ya = neg_sat(r.out[1], ioc_pkg::ACC_OFS_MAX);
  assign null_xt = neg_sat(r.out[2], ioc_pkg::TILT_OFS_MAX);
  assign null_yt = neg_sat(r.out[3], ioc_pkg::TILT_OFS_MAX);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        frame_ok;
  logic [5:0]  f_addr;
  logic [15:0] f_word;

  always_comb begin
    n = r;
    // first stage of each synchroniser feeds only the second
    n.sclk_p = {r.sclk_p[1:0], SCLK};
    n.csn_p  = {r.csn_p[1:0], CS_N};
    n.din_p  = {r.din_p[0], DIN};
    sclk_rise = r.sclk_p[1] & ~r.sclk_p[2];
    sclk_fall = ~r.sclk_p[1] & r.sclk_p[2];
    cs_fall   = ~r.csn_p[1] & r.csn_p[2];
    cs_rise   = r.csn_p[1] & ~r.csn_p[2];
    frame_ok  = cs_rise && (r.bit_cnt == ioc_pkg::FRAME_BITS);
    f_addr    = r.rx[ioc_pkg::ADDR_HI:ioc_pkg::ADDR_LO];
    f_word    = rd_word(r, f_addr[5:1]);
    n.out_valid = 1'b0;
    n.flash_req = 1'b0;

    unique case (r.phase)
      ioc_pkg::IOC_RESTORE: begin
        // a blank or torn store leaves the reset defaults in place
        if (nv_mem[ioc_pkg::NV_SIG_IDX] == ioc_pkg::NV_SIG) begin
          for (int i = 0; i < ioc_pkg::NV_SIG_IDX; i++) begin
            n = put_word(n, ioc_pkg::NV_BASE_W + 5'(i), nv_mem[i]);
          end
        end
        n.phase = ioc_pkg::IOC_RUN;
      end
      ioc_pkg::IOC_RUN: begin
        // serial shifter: sample on rising, shift out on falling
        // each SCLK phase must span three MCLK cycles or the synchroniser
        // merges two edges into none
        if (cs_fall) begin
          n.bit_cnt = 5'h00;
        end else if (!r.csn_p[1] && sclk_rise && r.bit_cnt != ioc_pkg::FRAME_BITS) begin
          n.rx      = {r.rx[14:0], r.din_p[1]};
          n.bit_cnt = r.bit_cnt + 5'h01;
        end
        // first falling edge precedes the first sample, so keep the msb
        if (!r.csn_p[1] && sclk_fall && r.bit_cnt != 5'h00) begin
          n.tx = {r.tx[14:0], 1'b0};
        end
        // a frame shorter than 16 bits is dropped whole (a longer one acts on its first 16 bits), so a cut frame
        // never writes half a byte into a calibration word
        if (frame_ok) begin
          if (r.rx[ioc_pkg::WR_BIT]) begin
            n.tx = 16'h0000;
            if (f_addr[0]) begin
              n = put_word(n, f_addr[5:1], {r.rx[7:0], f_word[7:0]});
            end else begin
              n = put_word(n, f_addr[5:1], {f_word[15:8], r.rx[7:0]});
            end
            if (f_addr == ioc_pkg::A_CMD && r.rx[ioc_pkg::CMD_NULL]) begin
              n.aofs[0] = null_xa;
              n.aofs[1] = null_ya;
              n.tofs[0] = null_xt[8:0];  // clamped to +255/-256, upper bits repeat the sign
              n.tofs[1] = null_yt[8:0];
            end
            if (f_addr == ioc_pkg::A_CMD && r.rx[ioc_pkg::CMD_FLASH]) begin
              n.flash_req = 1'b1;
            end
          end else begin
            n.tx = f_word;
          end
        end
        if (RAW_VALID) begin
          n.out       = cal_res;
          n.out_valid = 1'b1;
        end
      end
    endcase
    n.dout = n.tx[15];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      r <= RST_S;
    end else begin
      r <= n;
    end
  end

  // the store survives reset; one commit writes all words and the mark
  always_ff @(posedge MCLK) begin
    if (r.flash_req) begin
      for (int i = 0; i < ioc_pkg::NV_SIG_IDX; i++) begin
        nv_mem[i] <= rd_word(r, ioc_pkg::NV_BASE_W + 5'(i));
      end
      nv_mem[ioc_pkg::NV_SIG_IDX] <= ioc_pkg::NV_SIG;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every pin is a bit of r; no decode reaches a pin without a flop
  assign DOUT                 = r.dout;
  assign X_ACCEL_OUT          = r.out[0];
  assign Y_ACCEL_OUT          = r.out[1];
  assign X_TILT_OUT           = r.out[2];
  assign Y_TILT_OUT           = r.out[3];
  assign OUT_VALID            = r.out_valid;
  assign MOVING_AVERAGE_COUNT = r.avg;
endmodule
`default_nettype wire

// >>> test/ioc_host_model.sv
/*
  Serial host model: shifts 16-bit frames into the calibration block.
  Assumes the bench clock paces it; every change lands on a falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ioc_host_model (
  input  wire logic clk,  // bench clock
  output logic      sclk, // serial clock, idle high
  output logic      cs_n, // frame select
  output logic      din,  // data to the device
  input  wire logic dout  // data from the device
);
  // ----------------------------------------------------------------
  // one frame, msb first; phases kept at 6 clocks to clear the sync
  // ----------------------------------------------------------------
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int b;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (6) @(negedge clk);
    for (b = 15; b >= 0; b--) begin
      sclk = 1'b0;
      din  = tx[b];
      repeat (6) @(negedge clk);
      rx[b] = dout;
      sclk  = 1'b1;
      repeat (6) @(negedge clk);
    end
    cs_n = 1'b1;
    // idle line must not look like a held bit
    din = ~din;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test/ioc_checker.sv
/*
  Concurrent checks on the ports of the calibration block.
  Assumes it is bound into ioc_top; MCLK clocks, RST resets high.
*/
`timescale 1ns/10ps
`default_nettype none
module ioc_checker #(
  parameter int RAW_W = 14
) (
  input wire logic             MCLK,                // clock
  input wire logic             RST,                 // reset
  input wire logic             SCLK,                // serial clock
  input wire logic             CS_N,                // frame select
  input wire logic             DIN,                 // serial in
  input wire logic             DOUT,                // serial out
  input wire logic             RAW_VALID,           // raw strobe
  input wire logic [RAW_W-1:0] RAW_X_ACCEL,         // raw x accel
  input wire logic [RAW_W-1:0] RAW_Y_ACCEL,         // raw y accel
  input wire logic [RAW_W-1:0] RAW_X_TILT,          // raw x tilt
  input wire logic [RAW_W-1:0] RAW_Y_TILT,          // raw y tilt
  input wire logic [15:0]      X_ACCEL_OUT,         // x accel out
  input wire logic [15:0]      Y_ACCEL_OUT,         // y accel out
  input wire logic [15:0]      X_TILT_OUT,          // x tilt out
  input wire logic [15:0]      Y_TILT_OUT,          // y tilt out
  input wire logic             OUT_VALID,           // output strobe
  input wire logic [15:0]      MOVING_AVERAGE_COUNT // averaging count
);
  // ----------------------------------------------------------------
  // output timing, range and register side effects
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_sample;
    RAW_VALID ##1 OUT_VALID;
  endsequence
  a_valid_follows: assert property (RAW_VALID |-> s_sample)
    else $error("output strobe missing after raw strobe");
  a_valid_cause: assert property (OUT_VALID |-> $past(RAW_VALID))
    else $error("output strobe without raw strobe");
  a_accel_hold: assert property (!RAW_VALID |=> $stable(X_ACCEL_OUT) && $stable(Y_ACCEL_OUT))
    else $error("accel output moved without a sample");
  a_tilt_hold: assert property (!RAW_VALID |=> $stable(X_TILT_OUT) && $stable(Y_TILT_OUT))
    else $error("tilt output moved without a sample");
  a_accel_range: assert property (
      X_ACCEL_OUT[15:13] inside {3'h0, 3'h7} && Y_ACCEL_OUT[15:13] inside {3'h0, 3'h7})
    else $error("accel output outside sign-extended range");
  a_tilt_range: assert property (
      X_TILT_OUT[15:13] inside {3'h0, 3'h7} && Y_TILT_OUT[15:13] inside {3'h0, 3'h7})
    else $error("tilt output outside sign-extended range");
  a_avg_quiet: assert property ($changed(MOVING_AVERAGE_COUNT) |-> CS_N && $past(CS_N, 2))
    else $error("averaging count changed inside a frame");
  a_dout_still: assert property (CS_N && $past(CS_N, 8) |-> $stable(DOUT))
    else $error("serial out moved between frames");
endmodule
bind ioc_top ioc_checker #(.RAW_W(RAW_W)) u_chk (
  .MCLK(MCLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .RAW_VALID(RAW_VALID),
  .RAW_X_ACCEL(RAW_X_ACCEL), .RAW_Y_ACCEL(RAW_Y_ACCEL), .RAW_X_TILT(RAW_X_TILT), .RAW_Y_TILT(RAW_Y_TILT),
  .X_ACCEL_OUT(X_ACCEL_OUT), .Y_ACCEL_OUT(Y_ACCEL_OUT), .X_TILT_OUT(X_TILT_OUT), .Y_TILT_OUT(Y_TILT_OUT),
  .OUT_VALID(OUT_VALID), .MOVING_AVERAGE_COUNT(MOVING_AVERAGE_COUNT)
);
`default_nettype wire

// >>> test/ioc_top_tb.sv
/*
  Self-checking bench of the calibration block over its serial port.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module ioc_top_tb;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        raw_valid = 1'b0;
  logic        sclk, cs_n, din, dout, out_valid;
  logic [13:0] rxa = '0, rya = '0, rxt = '0, ryt = '0;
  logic [15:0] xa, ya, xt, yt, mac, v;
  logic [15:0] exp_reg [8];
  int          err_count = 0;
  int          n_compared = 0;
  int          i;
  always #12.5 mclk = ~mclk;
  ioc_host_model u_host (.clk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  ioc_top #(.RAW_W(14)) u_dut (
    .MCLK(mclk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout), .RAW_VALID(raw_valid),
    .RAW_X_ACCEL(rxa), .RAW_Y_ACCEL(rya), .RAW_X_TILT(rxt), .RAW_Y_TILT(ryt),
    .X_ACCEL_OUT(xa), .Y_ACCEL_OUT(ya), .X_TILT_OUT(xt), .Y_TILT_OUT(yt),
    .OUT_VALID(out_valid), .MOVING_AVERAGE_COUNT(mac)
  );
  // ----------------------------------------------------------------
  // access tasks and expectations
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] r;
    u_host.xfer({2'b10, a, d}, r);
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr(a | 6'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask
  // second frame reads reserved address 0, harmless
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    logic [15:0] r;
    u_host.xfer({2'b00, a, 8'h00}, r);
    u_host.xfer(16'h0000, d);
  endtask
  task automatic chk_all();
    for (int k = 0; k < 8; k++) begin
      rd(6'h10 + 6'(2 * k), v);
      chk("calibration register", exp_reg[k], v);
    end
  endtask
  // expected output of axis a (x accel, y accel, x tilt, y tilt)
  function automatic logic [15:0] cal(int r, int a);
    int oi, o, g, p;
    oi = a < 2 ? a : a + 2;
    o  = oi < 4 ? int'($signed(exp_reg[oi][11:0])) : int'($signed(exp_reg[oi][8:0]));
    g  = int'(exp_reg[oi + 2][11:0]);
    p  = ((r + o) * g) >>> 11;
    if (p > 8191) p = 8191;
    if (p < -8192) p = -8192;
    return p[15:0];
  endfunction
  task automatic sample(input int x, input int y, input int p, input int q);
    int k;
    @(negedge mclk);
    rxa = x[13:0];
    rya = y[13:0];
    rxt = p[13:0];
    ryt = q[13:0];
    raw_valid = 1'b1;
    @(negedge mclk);
    raw_valid = 1'b0;
    for (k = 0; k < 4 && out_valid !== 1'b1; k++) @(negedge mclk);
    if (k == 4) begin
      err_count++;
      report_and_stop();
    end else begin
      chk("x accel out", cal(x, 0), xa);
      chk("y accel out", cal(y, 1), ya);
      chk("x tilt out", cal(p, 2), xt);
      chk("y tilt out", cal(q, 3), yt);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    #1_000_000;
    err_count++;
    report_and_stop();
  end
  initial begin
    do_reset();
    for (i = 0; i < 8; i++) exp_reg[i] = i[1] ? 16'h0800 : 16'h0000;
    chk_all();
    rd(6'h15, v);
    chk("odd address read", 16'h0800, v);
    wr16(ioc_pkg::A_AVG, 16'h0008);
    chk("averaging count", 16'h0008, mac);
    sample(1000, -500, 100, 300);
    wr(ioc_pkg::A_CMD, 8'h01);
    exp_reg[0] = 16'h0C18;
    exp_reg[1] = 16'h01F4;
    exp_reg[4] = 16'h019C;
    exp_reg[5] = 16'h0100;
    chk_all();
    sample(1000, -500, 100, 300);
    for (i = 0; i < 8; i++) wr16(6'h10 + 6'(2 * i), 16'hFFFF);
    for (i = 0; i < 8; i++) exp_reg[i] = (i == 4 || i == 5) ? 16'h01FF : 16'h0FFF;
    chk_all();
    exp_reg = '{16'h0F9C, 16'h07FF, 16'h0400, 16'h0FFF, 16'h0100, 16'h00FF, 16'h0800, 16'h0000};
    for (i = 0; i < 8; i++) wr16(6'h10 + 6'(2 * i), exp_reg[i]);
    sample(1000, 7000, -8000, 500);
    wr(ioc_pkg::A_CMD, 8'h08);
    do_reset();
    chk_all();
    report_and_stop();
  end
endmodule
`default_nettype wire
